// ===== oat_pkg.sv
`default_nettype none

package oat_pkg;

    localparam int CLASS_W = 3;
    localparam int MODE_W = 3;
    localparam int REG_W = 3;
    localparam int UCYC_W = 4;
    localparam int RD_W = 3;
    localparam int WR_W = 2;
    localparam int ENTRY_W = UCYC_W + RD_W + WR_W;

    // Register field value that selects the program counter
    localparam logic [REG_W-1:0] PC_REG = 3'h7;

    typedef enum logic [CLASS_W-1:0] {
        OAT_READ_ONLY = 3'b000,
        OAT_WRITE_ONLY = 3'b001,
        OAT_READ_MODIFY_WRITE = 3'b010,
        OAT_JUMP_INSTRUCTION = 3'b011,
        OAT_SUBROUTINE_CALL_INSTRUCTION = 3'b100
    } oat_class_t;

    typedef enum logic [MODE_W-1:0] {
        OAT_MODE_REGISTER = 3'b000,
        OAT_MODE_DEFERRED = 3'b001,
        OAT_MODE_AUTOINC = 3'b010,
        OAT_MODE_AUTOINC_DEF = 3'b011,
        OAT_MODE_AUTODEC = 3'b100,
        OAT_MODE_AUTODEC_DEF = 3'b101,
        OAT_MODE_INDEX = 3'b110,
        OAT_MODE_INDEX_DEF = 3'b111
    } oat_mode_t;

    localparam logic RESET_VALID = 1'b0;
    localparam logic [ENTRY_W-1:0] RESET_ENTRY = 9'h000;

endpackage

`default_nettype wire

// ===== oat_out_reg.sv
`timescale 1ns/1ps
`default_nettype none

module oat_out_reg #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q_reg <= RESET_VALUE;
        end else begin
            q_reg <= d_i;
        end
    end

    assign q_o = q_reg;

endmodule

`default_nettype wire

// ===== oat_timing.sv
// Contract
// - A read-only single-operand destination costs 0 cycles and no reads in mode 0, 2 cycles and one read in modes 1 and 2 with registers 0-6, 4 cycles and two reads in mode 6, and 6 cycles and three reads in mode 7.
// - A write-only destination costs 5 cycles and one read in register mode on the program counter, exactly one write in every memory mode, and 9 cycles and two reads in mode 5 on the program counter.
// - A read-modify-write destination costs 3 cycles, one read and one write in mode 1 with registers 0-6, 10 cycles, three reads and one write in mode 5 on the program counter, and 7 cycles, three reads and one write in mode 7.
// - A jump instruction destination never writes, costing 4 cycles and two reads in mode 1, 5 cycles and three reads in mode 6 on the program counter, and 7 cycles and four reads in mode 7.
// - A subroutine call destination writes exactly once in modes 1-7, costing 9 cycles and two reads in mode 1, 9 rather than 10 cycles in modes 3 and 6
// on the program counter, and 12 cycles and four reads in mode 7.
`timescale 1ns/1ps
`default_nettype none

module oat_timing (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic [oat_pkg::CLASS_W-1:0] class_i,
    input wire logic [oat_pkg::MODE_W-1:0] mode_i,
    input wire logic [oat_pkg::REG_W-1:0] reg_i,
    output logic rsp_valid_o,
    output logic rsp_legal_o,
    output logic [oat_pkg::UCYC_W-1:0] ucycles_o,
    output logic [oat_pkg::RD_W-1:0] reads_o,
    output logic [oat_pkg::WR_W-1:0] writes_o
);

    localparam int EW = oat_pkg::ENTRY_W;

    function automatic logic [EW-1:0] ent(
        input logic [oat_pkg::UCYC_W-1:0] c,
        input logic [oat_pkg::RD_W-1:0] r,
        input logic [oat_pkg::WR_W-1:0] w
    );
        ent = {c, r, w};
    endfunction

    logic is_pc;
    logic legal_next;
    logic [EW-1:0] entry_next;
    logic [EW-1:0] entry_q;
    logic [1:0] stage_next;
    logic [1:0] stage_q;

    always_comb begin
        is_pc = (reg_i == oat_pkg::PC_REG);
        legal_next = 1'b1;
        entry_next = oat_pkg::RESET_ENTRY;
        unique case (class_i)
            oat_pkg::OAT_READ_ONLY: begin
                unique case (mode_i)
                    3'h0: entry_next = ent(4'h0, 3'h0, 2'h0);
                    3'h1: entry_next = ent(4'h2, 3'h1, 2'h0);
                    3'h2: entry_next = is_pc ? ent(4'h1, 3'h1, 2'h0)
                                             : ent(4'h2, 3'h1, 2'h0);
                    3'h3: entry_next = is_pc ? ent(4'h3, 3'h2, 2'h0)
                                             : ent(4'h4, 3'h2, 2'h0);
                    3'h4: entry_next = is_pc ? ent(4'h7, 3'h2, 2'h0)
                                             : ent(4'h3, 3'h1, 2'h0);
                    3'h5: entry_next = is_pc ? ent(4'h9, 3'h3, 2'h0)
                                             : ent(4'h5, 3'h2, 2'h0);
                    3'h6: entry_next = ent(4'h4, 3'h2, 2'h0);
                    3'h7: entry_next = ent(4'h6, 3'h3, 2'h0);
                endcase
            end
            oat_pkg::OAT_WRITE_ONLY: begin
                // Every memory mode writes once; the PC adds a read in modes 0, 1, 2, 4 and 5
                unique case (mode_i)
                    3'h0: entry_next = is_pc ? ent(4'h5, 3'h1, 2'h0)
                                             : ent(4'h0, 3'h0, 2'h0);
                    3'h1: entry_next = is_pc ? ent(4'h6, 3'h1, 2'h1)
                                             : ent(4'h2, 3'h0, 2'h1);
                    3'h2: entry_next = is_pc ? ent(4'h6, 3'h1, 2'h1)
                                             : ent(4'h2, 3'h0, 2'h1);
                    3'h3: entry_next = is_pc ? ent(4'h3, 3'h1, 2'h1)
                                             : ent(4'h4, 3'h1, 2'h1);
                    3'h4: entry_next = is_pc ? ent(4'h7, 3'h1, 2'h1)
                                             : ent(4'h3, 3'h0, 2'h1);
                    3'h5: entry_next = is_pc ? ent(4'h9, 3'h2, 2'h1)
                                             : ent(4'h5, 3'h1, 2'h1);
                    3'h6: entry_next = ent(4'h4, 3'h1, 2'h1);
                    3'h7: entry_next = ent(4'h6, 3'h2, 2'h1);
                endcase
            end
            oat_pkg::OAT_READ_MODIFY_WRITE: begin
                unique case (mode_i)
                    3'h0: entry_next = is_pc ? ent(4'h5, 3'h1, 2'h0)
                                             : ent(4'h0, 3'h0, 2'h0);
                    3'h1: entry_next = is_pc ? ent(4'h7, 3'h2, 2'h1)
                                             : ent(4'h3, 3'h1, 2'h1);
                    3'h2: entry_next = is_pc ? ent(4'h7, 3'h2, 2'h1)
                                             : ent(4'h3, 3'h1, 2'h1);
                    3'h3: entry_next = is_pc ? ent(4'h4, 3'h2, 2'h1)
                                             : ent(4'h5, 3'h2, 2'h1);
                    3'h4: entry_next = is_pc ? ent(4'h8, 3'h2, 2'h1)
                                             : ent(4'h4, 3'h1, 2'h1);
                    3'h5: entry_next = is_pc ? ent(4'hA, 3'h3, 2'h1)
                                             : ent(4'h6, 3'h2, 2'h1);
                    3'h6: entry_next = ent(4'h5, 3'h2, 2'h1);
                    3'h7: entry_next = ent(4'h7, 3'h3, 2'h1);
                endcase
            end
            oat_pkg::OAT_JUMP_INSTRUCTION: begin
                // Register mode has no address to jump to, so it is illegal
                unique case (mode_i)
                    3'h0: legal_next = 1'b0;
                    3'h1: entry_next = ent(4'h4, 3'h2, 2'h0);
                    3'h2: entry_next = ent(4'h6, 3'h2, 2'h0);
                    3'h3: entry_next = ent(4'h5, 3'h3, 2'h0);
                    3'h4: entry_next = ent(4'h5, 3'h2, 2'h0);
                    3'h5: entry_next = ent(4'h6, 3'h3, 2'h0);
                    3'h6: entry_next = is_pc ? ent(4'h5, 3'h3, 2'h0)
                                             : ent(4'h6, 3'h3, 2'h0);
                    3'h7: entry_next = ent(4'h7, 3'h4, 2'h0);
                endcase
            end
            oat_pkg::OAT_SUBROUTINE_CALL_INSTRUCTION: begin
                unique case (mode_i)
                    3'h0: legal_next = 1'b0;
                    3'h1: entry_next = ent(4'h9, 3'h2, 2'h1);
                    3'h2: entry_next = ent(4'hA, 3'h2, 2'h1);
                    3'h3: entry_next = is_pc ? ent(4'h9, 3'h3, 2'h1)
                                             : ent(4'hA, 3'h3, 2'h1);
                    3'h4: entry_next = ent(4'hA, 3'h2, 2'h1);
                    3'h5: entry_next = ent(4'hB, 3'h3, 2'h1);
                    3'h6: entry_next = is_pc ? ent(4'h9, 3'h3, 2'h1)
                                             : ent(4'hA, 3'h3, 2'h1);
                    3'h7: entry_next = ent(4'hC, 3'h4, 2'h1);
                endcase
            end
            default: legal_next = 1'b0;
        endcase
        // Illegal requests answer with all-zero counts
        if (!legal_next) begin
            entry_next = oat_pkg::RESET_ENTRY;
        end
        stage_next = {req_valid_i, req_valid_i & legal_next};
    end

    oat_out_reg #(
        .WIDTH(EW),
        .RESET_VALUE(oat_pkg::RESET_ENTRY)
    ) u_entry (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(entry_next),
        .q_o(entry_q)
    );

    oat_out_reg #(
        .WIDTH(2),
        .RESET_VALUE({oat_pkg::RESET_VALID, oat_pkg::RESET_VALID})
    ) u_stage (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(stage_next),
        .q_o(stage_q)
    );

    assign rsp_valid_o = stage_q[1];
    assign rsp_legal_o = stage_q[0];
    assign ucycles_o = entry_q[EW-1 -: oat_pkg::UCYC_W];
    assign reads_o = entry_q[oat_pkg::WR_W +: oat_pkg::RD_W];
    assign writes_o = entry_q[oat_pkg::WR_W-1:0];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Request fields one edge back, so the registered answer can be judged
    logic [oat_pkg::CLASS_W-1:0] rq_class_reg;
    logic [oat_pkg::MODE_W-1:0] rq_mode_reg;
    logic rq_pc_reg;

    always_ff @(posedge mclk_i) begin
        rq_class_reg <= class_i;
        rq_mode_reg <= mode_i;
        rq_pc_reg <= is_pc;
    end

    chk_ro_mode_ends: assert property (
        rsp_valid_o && rq_class_reg == oat_pkg::OAT_READ_ONLY
        && (rq_mode_reg == 3'h0 || rq_mode_reg == 3'h7)
        |-> (rq_mode_reg == 3'h0)
            ? (ucycles_o == 4'h0 && reads_o == 3'h0)
            : (ucycles_o == 4'h6 && reads_o == 3'h3))
        else $error("read-only mode 0/7 counts wrong");
    chk_wo_one_write: assert property (
        req_valid_i && class_i == oat_pkg::OAT_WRITE_ONLY && mode_i != 3'h0
        ##1 1'b1 |-> writes_o == 2'h1 && rsp_legal_o)
        else $error("write-only memory mode not one write");
    chk_wo_pc_reg: assert property (
        req_valid_i && class_i == oat_pkg::OAT_WRITE_ONLY && mode_i == 3'h0
        && reg_i == oat_pkg::PC_REG
        |=> ucycles_o == 4'h5 && reads_o == 3'h1 && writes_o == 2'h0)
        else $error("write-only pc register mode wrong");
    chk_rmw_pc_m5: assert property (
        req_valid_i && class_i == oat_pkg::OAT_READ_MODIFY_WRITE
        && mode_i == 3'h5 && reg_i == oat_pkg::PC_REG
        |=> ucycles_o == 4'hA && reads_o == 3'h3 && writes_o == 2'h1)
        else $error("rmw mode 5 pc counts wrong");
    chk_jump_no_write: assert property (
        rsp_valid_o && rq_class_reg == oat_pkg::OAT_JUMP_INSTRUCTION
        |-> writes_o == 2'h0
        && (rq_mode_reg != 3'h7 || (ucycles_o == 4'h7 && reads_o == 3'h4)))
        else $error("jump destination counts wrong");
    chk_call_pc_saving: assert property (
        rsp_valid_o
        && rq_class_reg == oat_pkg::OAT_SUBROUTINE_CALL_INSTRUCTION
        && rsp_legal_o && rq_pc_reg
        && (rq_mode_reg == 3'h3 || rq_mode_reg == 3'h6)
        |-> ucycles_o == 4'h9)
        else $error("call pc mode 3/6 not 9 cycles");
    chk_call_one_write: assert property (
        rsp_valid_o
        && rq_class_reg == oat_pkg::OAT_SUBROUTINE_CALL_INSTRUCTION
        && rq_mode_reg != 3'h0
        |-> writes_o == 2'h1 && rsp_legal_o)
        else $error("call destination not one write");
    chk_pc_selects: assert property (
        req_valid_i && class_i == oat_pkg::OAT_READ_ONLY && mode_i == 3'h2
        |=> ucycles_o == (rq_pc_reg ? 4'h1 : 4'h2) && reads_o == 3'h1)
        else $error("register 7 not treated as pc");
    chk_valid_follows: assert property (
        req_valid_i |=> rsp_valid_o)
        else $error("response valid not one cycle after request");
    chk_valid_quiet: assert property (
        !req_valid_i |=> !rsp_valid_o)
        else $error("response valid without a request");
    // Refused requests must not leak counts that look like a real entry
    chk_refused_zero: assert property (
        rsp_valid_o && !rsp_legal_o
        |-> ucycles_o == 4'h0 && reads_o == 3'h0 && writes_o == 2'h0)
        else $error("refused request answered with counts");

    cov_rmw_pc: cover property (
        req_valid_i && class_i == 3'h2 && reg_i == 3'h7 ##1 rsp_valid_o);
    cov_jump_illegal: cover property (
        req_valid_i && class_i == 3'h3 && mode_i == 3'h0 ##1 !rsp_legal_o);
    cov_call_back_to_back: cover property (
        req_valid_i && class_i == 3'h4 ##1 req_valid_i ##1 rsp_valid_o);

endmodule

`default_nettype wire

// ===== test_operand_address_timing.sv
`timescale 1ns/1ps
`default_nettype none

module test_operand_address_timing;
    // Two entries per mode, registers 0-6 then the program counter,
    // each entry three digits: cycles, reads, writes
    localparam logic [191:0] TBL [5] = '{
        {96'h000000210210210110420320, 96'h310720520930420420630630},
        {96'h000510201611201611411311, 96'h301711511921411411621621},
        {96'h000510311721311721521421, 96'h411821621A31521521731731},
        {96'h000000420420620620530530, 96'h520520630630630530740740},
        {96'h000000921921A21A21A31931, 96'hA21A21B31B31A31931C41C41}
    };
    localparam int LIMIT = 3000;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [2:0] cls = 3'h0;
    logic [2:0] mode = 3'h0;
    logic [2:0] regf = 3'h0;
    logic rsp_valid;
    logic rsp_legal;
    logic [3:0] ucycles;
    logic [2:0] reads;
    logic [1:0] writes;
    logic pend_v = 1'b0;
    logic [9:0] pend_e = 10'h000;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    oat_timing dut_u (
        .mclk_i(mclk),
        .rst_i(rst),
        .req_valid_i(req_valid),
        .class_i(cls),
        .mode_i(mode),
        .reg_i(regf),
        .rsp_valid_o(rsp_valid),
        .rsp_legal_o(rsp_legal),
        .ucycles_o(ucycles),
        .reads_o(reads),
        .writes_o(writes)
    );

    always #2.5 mclk = ~mclk;

    // Jump and call have no register-mode row, classes 5-7 none at all
    function automatic logic [9:0] expect_of(logic [2:0] c, m, r);
        logic [11:0] e;
        int k;
        if (c > 3'h4 || (c >= 3'h3 && m == 3'h0))
            return 10'h000;
        k = 2 * int'(m) + int'(r == oat_pkg::PC_REG);
        e = TBL[c][191 - 12 * k -: 12];
        return {1'b1, e[11:8], e[6:4], e[1:0]};
    endfunction

    task automatic chk_bit(string name, logic exp, logic got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask

    task automatic chk_cnt(string name, logic [8:0] exp, logic [8:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic check_out();
        chk_bit("rsp_valid", pend_v, rsp_valid);
        if (pend_v) begin
            chk_bit("rsp_legal", pend_e[9], rsp_legal);
            chk_cnt("counts", pend_e[8:0], {ucycles, reads, writes});
        end
    endtask

    // Answer to the previous request is judged 1 ns after the edge that drives this one
    task automatic step(logic v, logic [2:0] c, m, r);
        @(posedge mclk);
        req_valid <= v;
        cls <= c;
        mode <= m;
        regf <= r;
        #1;
        check_out();
        pend_v = v;
        pend_e = expect_of(c, m, r);
    endtask

    task automatic t_reset_values();
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk_bit("rsp_valid", 1'b0, rsp_valid);
        chk_cnt("counts", 9'h000, {ucycles, reads, writes});
    endtask

    // Every mode and register back to back, no idle cycle between requests
    task automatic t_class(logic [2:0] c);
        for (int i = 0; i < 64; i++)
            step(1'b1, c, i[5:3], i[2:0]);
        step(1'b0, 3'h0, 3'h0, 3'h0);
    endtask

    task automatic t_illegal();
        for (int c = 5; c < 8; c++)
            step(1'b1, c[2:0], 3'h6, 3'h7);
        step(1'b1, 3'h3, 3'h0, 3'h7);
        step(1'b1, 3'h4, 3'h0, 3'h2);
        step(1'b0, 3'h0, 3'h0, 3'h0);
    endtask

    // A request taken during reset must not be answered
    task automatic t_mid_reset();
        step(1'b1, 3'h2, 3'h5, 3'h7);
        step(1'b1, 3'h4, 3'h7, 3'h1);
        // The call still stands while reset is raised on this edge
        @(posedge mclk);
        rst <= 1'b1;
        #1;
        check_out();
        @(posedge mclk);
        rst <= 1'b0;
        req_valid <= 1'b0;
        #1;
        chk_bit("rsp_valid", 1'b0, rsp_valid);
        chk_cnt("counts", 9'h000, {ucycles, reads, writes});
        pend_v = 1'b0;
        step(1'b1, 3'h1, 3'h0, 3'h7);
        step(1'b0, 3'h0, 3'h0, 3'h0);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        t_reset_values();
        t_class(3'h0);
        t_class(3'h1);
        t_class(3'h2);
        t_class(3'h3);
        t_class(3'h4);
        t_illegal();
        t_mid_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
